// >>> pkg/fdpo_params.svh
// constants for the frequency discriminator and parallel output block
`ifndef FDPO_PARAMS_SVH
`define FDPO_PARAMS_SVH
// discriminator configuration word fields
`define FDPO_CFG_DELAY_LSB   0
`define FDPO_CFG_DELAY_MSB   2
`define FDPO_CFG_TAPS_LSB    3
`define FDPO_CFG_TAPS_MSB    8
`define FDPO_CFG_ASYM_BIT    9
`define FDPO_CFG_ODD_BIT     10
`define FDPO_CFG_DECIM_LSB   11
`define FDPO_CFG_DECIM_MSB   13
`define FDPO_CFG_ENABLE_BIT  14
`define FDPO_CFG_PMUL_LSB    15
`define FDPO_CFG_PMUL_MSB    16
`define FDPO_CFG_RESET       32'h0000_0000
// datapath option word fields
`define FDPO_OPT_QZERO_BIT   14
`define FDPO_OPT_FSEL_LSB    18
`define FDPO_OPT_FSEL_MSB    19
// output format word fields
`define FDPO_FMT_BSEL_LSB    20
`define FDPO_FMT_BSEL_MSB    21
`define FDPO_FMT_ASEL_LSB    22
`define FDPO_FMT_ASEL_MSB    23
`define FDPO_FMT_MODE_BIT    25
// fir sizes
`define FDPO_MAX_TAPS_SYM    63
`define FDPO_MAX_TAPS_ASYM   32
`define FDPO_MAX_DELAY       8
`define FDPO_ACC_W           40
`define FDPO_ROUND_BIT       17
`define FDPO_ROUND_ADD       40'h00_0002_0000
`define FDPO_OUT_LSB         18
`endif

// >>> pkg/fdpo_pkg.sv
// types for the frequency discriminator and parallel output block
package fdpo_pkg;
    typedef enum logic [1:0] {
        FDPO_SRC_PHASE = 2'b00,
        FDPO_SRC_MAG   = 2'b01,
        FDPO_SRC_RSI   = 2'b10,
        FDPO_SRC_RSI2  = 2'b11
    } fdpo_fsel_t;

    // parallel word source codes
    typedef enum logic [1:0] {
        FDPO_A_I    = 2'b00,
        FDPO_A_MAG  = 2'b01,
        FDPO_A_FREQ = 2'b10
    } fdpo_asel_t;

    typedef enum logic [1:0] {
        FDPO_B_Q   = 2'b00,
        FDPO_B_PH  = 2'b01,
        FDPO_B_MAG = 2'b10
    } fdpo_bsel_t;

    typedef enum logic [1:0] {
        FDPO_ST_IDLE = 2'b00,
        FDPO_ST_MAC  = 2'b01,
        FDPO_ST_OUT  = 2'b10
    } fdpo_fir_st_t;

    typedef struct packed {
        logic [17:0] i;
        logic [17:0] q;
        logic        strobe;
    } fdpo_iq_t;

    typedef struct packed {
        logic [17:0] mag;
        logic [17:0] phase;
        logic        strobe;
    } fdpo_polar_t;

    typedef struct packed {
        logic [15:0] word_a;
        logic [15:0] word_b;
        logic        strobe;
    } fdpo_par_t;
endpackage

// >>> verification/fdpo_capture_model.sv
// downstream capture logic that takes both parallel words on the strobe
`timescale 1ns/100ps
`default_nettype none
module fdpo_capture_model (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [15:0]  word_a_in,
    input  wire logic [15:0]  word_b_in,
    input  wire logic         strobe_in,
    output logic      [15:0]  last_a_out,
    output logic      [15:0]  last_b_out,
    output logic      [31:0]  count_out
);
    // words are only trusted in the strobe cycle, as a real processor would
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            last_a_out <= 16'h0000;
            last_b_out <= 16'h0000;
            count_out  <= 32'h0000_0000;
        end else if (strobe_in) begin
            last_a_out <= word_a_in;
            last_b_out <= word_b_in;
            count_out  <= count_out + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// >>> verification/fdpo_properties.sv
// concurrent checks on the ports of the discriminator and parallel output block
`timescale 1ns/100ps
`default_nettype none
module fdpo_properties (
    input wire logic                   sys_clk_in,
    input wire logic                   rst_n_in,
    input wire logic                   ce_in,
    input wire logic                   cfg_we_in,
    input wire logic [31:0]            cfg_in,
    input wire logic [31:0]            path_option_in,
    input wire logic [31:0]            out_format_in,
    input wire logic                   resampler_enable_in,
    input wire logic                   agc_ready_in,
    input wire logic                   resampler_ready_in,
    input wire fdpo_pkg::fdpo_iq_t     agc_iq_in,
    input wire fdpo_pkg::fdpo_iq_t     resampler_iq_in,
    input wire fdpo_pkg::fdpo_polar_t  converter_in,
    input wire logic [31:0]            cfg_out,
    input wire fdpo_pkg::fdpo_iq_t     converter_iq_out,
    input wire logic [15:0]            parallel_word_a_out,
    input wire logic [15:0]            parallel_word_b_out,
    input wire logic                   output_word_strobe_out
);
    import fdpo_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_cfg_readback: assert property (
        ce_in && cfg_we_in |=> cfg_out == $past(cfg_in)) else $error("cfg readback wrong");
    chk_agc_load: assert property (
        ce_in && agc_ready_in && !resampler_enable_in |=> converter_iq_out.strobe
        && converter_iq_out.i == $past(agc_iq_in.i)) else $error("converter not loaded from agc");
    chk_resampler_load: assert property (
        ce_in && resampler_ready_in && resampler_enable_in |=> converter_iq_out.strobe
        && converter_iq_out.i == $past(resampler_iq_in.i)) else $error("converter not loaded from resampler");
    chk_q_zeroed: assert property (
        ce_in && path_option_in[14] && agc_ready_in && !resampler_enable_in
        |=> converter_iq_out.q == 18'h0) else $error("converter q not zeroed");
    chk_i_word_a: assert property (
        ce_in && agc_ready_in && !resampler_enable_in && out_format_in[23:22] == 2'h0 && !out_format_in[25]
        |-> ##2 output_word_strobe_out && parallel_word_a_out == $past(agc_iq_in.i[17:2], 2))
        else $error("word a i update wrong");
    chk_mag_word_a: assert property (
        ce_in && converter_in.strobe && out_format_in[23:22] == 2'h1 && !out_format_in[25]
        |=> output_word_strobe_out && parallel_word_a_out == $past(converter_in.mag[17:2]))
        else $error("word a magnitude update wrong");
    chk_phase_word_b: assert property (
        ce_in && converter_in.strobe && out_format_in[21:20] == 2'h1 && !out_format_in[25]
        |=> parallel_word_b_out == $past(converter_in.phase[17:2])) else $error("word b phase update wrong");
    chk_mode_hold: assert property (
        $past(out_format_in[25]) |-> $stable(parallel_word_a_out) && $stable(parallel_word_b_out))
        else $error("words moved outside parallel mode");
    chk_word_a_hold: assert property (
        $changed(parallel_word_a_out) |-> output_word_strobe_out) else $error("word a changed without strobe");
endmodule
bind fdpo_top fdpo_properties chk_u (.sys_clk_in, .rst_n_in, .ce_in, .cfg_we_in, .cfg_in, .path_option_in,
    .out_format_in, .resampler_enable_in, .agc_ready_in, .resampler_ready_in, .agc_iq_in, .resampler_iq_in,
    .converter_in, .cfg_out, .converter_iq_out, .parallel_word_a_out, .parallel_word_b_out, .output_word_strobe_out);
`default_nettype wire

// >>> verification/test_freq_discriminator_parallel_out.sv
// directed testbench for the discriminator and parallel output block
`timescale 1ns/100ps
`default_nettype none
module test_freq_discriminator_parallel_out;
    import fdpo_pkg::*;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1, cfg_we_in = 1'b0, coef_we_in = 1'b0;
    logic resampler_enable_in = 1'b0, agc_ready_in = 1'b0, resampler_ready_in = 1'b0;
    logic [31:0] cfg_in = 32'h0, path_option_in = 32'h0, out_format_in = 32'h0, cfg_out, n0, ncap;
    fdpo_iq_t    agc_iq_in = '0, resampler_iq_in = '0, converter_iq_out;
    fdpo_polar_t converter_in = '0;
    logic [5:0]  coef_addr_in = 6'h00;
    logic [17:0] coef_in = 18'h00000, ph;
    logic [15:0] parallel_word_a_out, parallel_word_b_out, la, lb;
    logic        output_word_strobe_out;
    int          n_fail = 0, checks = 0, cyc = 0;

    fdpo_top dut_u (.sys_clk_in, .rst_n_in, .ce_in, .cfg_we_in, .cfg_in, .path_option_in, .out_format_in,
        .resampler_enable_in, .agc_ready_in, .resampler_ready_in, .agc_iq_in, .resampler_iq_in, .converter_in,
        .coef_we_in, .coef_addr_in, .coef_in, .cfg_out, .converter_iq_out, .parallel_word_a_out,
        .parallel_word_b_out, .output_word_strobe_out);
    fdpo_capture_model cap_u (.sys_clk_in, .rst_n_in, .word_a_in(parallel_word_a_out),
        .word_b_in(parallel_word_b_out), .strobe_in(output_word_strobe_out), .last_a_out(la),
        .last_b_out(lb), .count_out(ncap));

    always #20 sys_clk_in = ~sys_clk_in;
    // -------------------------------------------------------------------------
    // bus tasks
    // -------------------------------------------------------------------------
    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_cfg(input logic [31:0] v);
        cfg_in = v; cfg_we_in = 1'b1; tick(); cfg_we_in = 1'b0;
    endtask
    task automatic agc(input logic [17:0] i, input logic [17:0] q);
        agc_iq_in.i = i; agc_iq_in.q = q; agc_ready_in = 1'b1; tick(); agc_ready_in = 1'b0;
    endtask
    task automatic cv(input logic [17:0] m, input logic [17:0] p);
        converter_in = {m, p, 1'b1}; tick(); converter_in.strobe = 1'b0;
    endtask
    // bounded wait: a missing strobe shows up as a stale capture
    task automatic wait_cap();
        logic [31:0] c0;
        c0 = ncap;
        for (int k = 0; k < 40 && ncap == c0; k++) tick();
    endtask
    // one tap, asymmetric, odd symmetry off
    function automatic logic [31:0] fcfg(input logic [2:0] d, input logic [1:0] pm, input logic en,
                                         input logic [2:0] dec);
        return {15'h0, pm, en, dec, 1'b0, 1'b1, 6'h01, d};
    endfunction
    function automatic logic [31:0] ffmt(input logic md, input logic [1:0] a, input logic [1:0] b);
        return {6'h00, md, 1'b0, a, b, 20'h00000};
    endfunction
    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end
    // -------------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------------
    initial begin
        tick(2);
        rst_n_in = 1'b1;
        chk("reset word a", 32'h0, parallel_word_a_out);
        chk("reset strobe", 32'h0, output_word_strobe_out);
        wr_cfg(32'hA5A5_5A5A);
        chk("cfg readback", 32'hA5A5_5A5A, cfg_out);
        ce_in = 1'b0; tick(); wr_cfg(32'h0); ce_in = 1'b1;
        chk("ce freeze", 32'hA5A5_5A5A, cfg_out);
        agc(18'h12345, 18'h2ABCD);
        chk("converter i", 32'h12345, converter_iq_out.i);
        tick();
        chk("word a i", 32'h48D1, parallel_word_a_out);
        chk("word b q", 32'hAAF3, parallel_word_b_out);
        chk("strobe first", 32'h1, output_word_strobe_out);
        tick();
        chk("strobe after", 32'h0, output_word_strobe_out);
        path_option_in = 32'h0000_4000;
        agc(18'h11111, 18'h22222);
        chk("converter q zero", 32'h0, converter_iq_out.q);
        path_option_in = 32'h0;
        resampler_enable_in = 1'b1;
        tick();
        agc(18'h3FFFF, 18'h0);
        chk("agc ignored", 32'h0, converter_iq_out.strobe);
        resampler_iq_in.i = 18'h0F0F0;
        resampler_ready_in = 1'b1; tick(); resampler_ready_in = 1'b0;
        chk("resampler i", 32'h0F0F0, converter_iq_out.i);
        resampler_enable_in = 1'b0;
        tick(3);
        out_format_in = ffmt(1'b0, 2'h1, 2'h1);
        cv(18'h0ABCC, 18'h31234);
        chk("word a mag", 32'h2AF3, parallel_word_a_out);
        chk("word b phase", 32'hC48D, parallel_word_b_out);
        out_format_in = ffmt(1'b0, 2'h1, 2'h2); tick();
        cv(18'h00400, 18'h0);
        chk("word b mag", 32'h0100, parallel_word_b_out);
        out_format_in = ffmt(1'b1, 2'h1, 2'h1);
        tick();
        cv(18'h3FFFC, 18'h3FFFC);
        tick();
        chk("mode hold", 32'h0100, parallel_word_a_out);
        // frequency on word a, single coefficient giving a gain of one quarter
        out_format_in = ffmt(1'b0, 2'h2, 2'h1);
        coef_in = 18'h10000; coef_we_in = 1'b1; tick(); coef_we_in = 1'b0;
        for (int d = 0; d < 8; d++) begin
            wr_cfg(fcfg(d[2:0], 2'h0, 1'b1, 3'h0));
            ph = 18'h3E000;
            for (int k = 0; k < 9; k++) begin
                cv(18'h0, ph);
                ph = ph + 18'h00400;
                wait_cap();
            end
            chk("freq delay", (d == 0 ? 8 : d) * 32'h100, la);
        end
        for (int m = 0; m < 4; m++) begin
            wr_cfg(fcfg(3'h1, m[1:0], 1'b1, 3'h0));
            cv(18'h0, 18'h3FF00); wait_cap();
            cv(18'h0, 18'h00300); wait_cap();
            chk("freq multiply", 32'h100 << m, la);
        end
        wr_cfg(fcfg(3'h1, 2'h0, 1'b1, 3'h1));
        n0 = ncap;
        repeat (4) begin
            cv(18'h0, ph); ph = ph + 18'h00400; wait_cap();
        end
        chk("decimated strobes", 32'h2, ncap - n0);
        wr_cfg(fcfg(3'h1, 2'h0, 1'b0, 3'h0));
        n0 = ncap;
        cv(18'h0, 18'h01000); wait_cap();
        cv(18'h0, 18'h02000); wait_cap();
        chk("disabled strobes", 32'h0, ncap - n0);
        path_option_in = {12'h000, 2'h1, 18'h00000};
        // two symmetric taps: even folds to a sum, odd to a difference
        for (int s = 0; s < 2; s++) begin
            wr_cfg({17'h00000, 1'b1, 3'h0, s[0], 1'b0, 6'h02, 3'h1});
            cv(18'h00100, 18'h0); wait_cap();
            cv(18'h00300, 18'h0); wait_cap();
            chk("fir symmetry", s ? 32'h80 : 32'h100, la);
        end
        wr_cfg(fcfg(3'h1, 2'h0, 1'b1, 3'h0));
        cv(18'h00006, 18'h2AAAA); wait_cap();
        chk("freq from mag rounded", 32'h2, la);
        path_option_in = {12'h000, 2'h2, 18'h00000};
        resampler_enable_in = 1'b1;
        resampler_iq_in.i = 18'h00404;
        resampler_ready_in = 1'b1; tick(); resampler_ready_in = 1'b0;
        cv(18'h0, 18'h0); wait_cap(); tick(40);
        chk("freq from resampler i", 32'h101, la);
        results();
    end
endmodule
`default_nettype wire

// >>> verilog/fdpo_fir.sv
// decimating fir filter for the discriminator path
`timescale 1ns/100ps
`default_nettype none
`include "fdpo_params.svh"
module fdpo_fir (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         ce_in,
    input  wire logic         sample_valid_in,
    input  wire logic [17:0]  sample_in,
    input  wire logic [5:0]   taps_in,
    input  wire logic         asym_in,
    input  wire logic         odd_sym_in,
    input  wire logic [2:0]   decim_in,
    input  wire logic         coef_we_in,
    input  wire logic [5:0]   coef_addr_in,
    input  wire logic [17:0]  coef_in,
    output logic              out_valid_out,
    output logic [15:0]       out_data_out
);
    import fdpo_pkg::*;

    logic [17:0] coef_mem [0:`FDPO_MAX_TAPS_SYM-1];
    logic [17:0] line_mem [0:`FDPO_MAX_TAPS_SYM-1];

    typedef struct packed {
        fdpo_fir_st_t             st;
        logic [5:0]               idx;
        logic [2:0]               dcnt;
        logic [`FDPO_ACC_W-1:0]   acc;
        logic                     valid;
        logic [15:0]              data;
    } fdpo_fir_state_t;

    fdpo_fir_state_t r;
    fdpo_fir_state_t next_r;
    logic [5:0]  ntaps;
    logic [5:0]  half;
    logic [18:0] pre;
    logic [`FDPO_ACC_W-1:0] prod;

    // clamp tap count to the structure's ceiling
    always_comb begin
        if (asym_in) begin
            ntaps = (taps_in > 6'(`FDPO_MAX_TAPS_ASYM)) ? 6'(`FDPO_MAX_TAPS_ASYM) : taps_in;
        end else begin
            ntaps = (taps_in > 6'(`FDPO_MAX_TAPS_SYM)) ? 6'(`FDPO_MAX_TAPS_SYM) : taps_in;
        end
        // widen first: 63 taps plus one must not wrap to zero
        half = 6'((7'(ntaps) + 7'h01) >> 1);
    end

    // symmetric fold: pair tap k with ntaps-1-k; odd symmetry subtracts
    always_comb begin
        logic [5:0]  mirror;
        logic        centre;
        mirror = 6'(ntaps - 6'h01 - r.idx);
        centre = (mirror == r.idx);
        if (asym_in || centre) begin
            pre = {line_mem[r.idx][17], line_mem[r.idx]};
        end else if (odd_sym_in) begin
            pre = 19'({line_mem[r.idx][17], line_mem[r.idx]} - {line_mem[mirror][17], line_mem[mirror]});
        end else begin
            pre = 19'({line_mem[r.idx][17], line_mem[r.idx]} + {line_mem[mirror][17], line_mem[mirror]});
        end
        prod = `FDPO_ACC_W'($signed(pre) * $signed(coef_mem[r.idx]));
    end

    always_comb begin
        logic [`FDPO_ACC_W-1:0] rnd;
        rnd = '0;
        next_r = r;
        next_r.valid = 1'b0;
        unique case (r.st)
            FDPO_ST_IDLE: begin
                if (sample_valid_in) begin
                    // decimation: only every (decim+1)th input starts a sum
                    if (r.dcnt >= decim_in) begin
                        next_r.dcnt = 3'h0;
                        next_r.st = FDPO_ST_MAC;
                        next_r.idx = 6'h00;
                        next_r.acc = '0;
                    end else begin
                        next_r.dcnt = 3'(r.dcnt + 3'h1);
                    end
                end
            end
            FDPO_ST_MAC: begin
                next_r.acc = `FDPO_ACC_W'(r.acc + prod);
                next_r.idx = 6'(r.idx + 6'h01);
                if (6'(r.idx + 6'h01) >= (asym_in ? ntaps : half)) begin
                    next_r.st = FDPO_ST_OUT;
                end
            end
            FDPO_ST_OUT: begin
                // asymmetric round: add half lsb, truncate
                rnd = `FDPO_ACC_W'(r.acc + `FDPO_ROUND_ADD);
                next_r.data = rnd[`FDPO_OUT_LSB+15:`FDPO_OUT_LSB];
                next_r.valid = 1'b1;
                next_r.st = FDPO_ST_IDLE;
            end
            default: next_r.st = FDPO_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            r <= '{st: FDPO_ST_IDLE, default: '0};
        end else if (ce_in) begin
            r <= next_r;
        end
    end

    // delay line and coefficient store, no reset needed for data
    always_ff @(posedge sys_clk_in) begin
        if (ce_in) begin
            if (sample_valid_in) begin
                line_mem[0] <= sample_in;
                for (int k = 1; k < `FDPO_MAX_TAPS_SYM; k++) begin
                    line_mem[k] <= line_mem[k-1];
                end
            end
            if (coef_we_in && coef_addr_in < 6'(`FDPO_MAX_TAPS_SYM)) begin
                coef_mem[coef_addr_in] <= coef_in;
            end
        end
    end

    assign out_valid_out = r.valid;
    assign out_data_out  = r.data;
endmodule
`default_nettype wire

// >>> verilog/fdpo_top.sv
// frequency discriminator with parallel direct output port
`timescale 1ns/100ps
`default_nettype none
`include "fdpo_params.svh"
module fdpo_top (
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 ce_in,
    input  wire logic                 cfg_we_in,
    input  wire logic [31:0]          cfg_in,
    input  wire logic [31:0]          path_option_in,
    input  wire logic [31:0]          out_format_in,
    input  wire logic                 resampler_enable_in,
    input  wire logic                 agc_ready_in,
    input  wire logic                 resampler_ready_in,
    input  wire fdpo_pkg::fdpo_iq_t   agc_iq_in,
    input  wire fdpo_pkg::fdpo_iq_t   resampler_iq_in,
    input  wire fdpo_pkg::fdpo_polar_t converter_in,
    input  wire logic                 coef_we_in,
    input  wire logic [5:0]           coef_addr_in,
    input  wire logic [17:0]          coef_in,
    output logic [31:0]               cfg_out,
    output fdpo_pkg::fdpo_iq_t        converter_iq_out,
    output logic [15:0]               parallel_word_a_out,
    output logic [15:0]               parallel_word_b_out,
    output logic                      output_word_strobe_out
);
    import fdpo_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [31:0]       cfg;
        logic [`FDPO_MAX_DELAY-1:0][17:0] hist;
        fdpo_iq_t          conv_iq;
        fdpo_iq_t          sym_iq;
        logic [17:0]       fir_in;
        logic              fir_in_valid;
        fdpo_par_t         par;
        logic [15:0]       freq;
        logic              freq_new;
    } fdpo_state_t;

    fdpo_state_t r;
    fdpo_state_t next_r;

    // ---------------------------------------------------------------
    // config decode
    // ---------------------------------------------------------------
    logic [2:0]  cfg_delay;
    logic [5:0]  cfg_taps;
    logic        cfg_asym;
    logic        cfg_odd;
    logic [2:0]  cfg_decim;
    logic        cfg_enable;
    logic [1:0]  cfg_pmul;
    fdpo_fsel_t  fir_sel;
    logic        q_zero;
    fdpo_asel_t  a_sel;
    fdpo_bsel_t  b_sel;
    logic        par_mode;

    assign cfg_delay  = r.cfg[`FDPO_CFG_DELAY_MSB:`FDPO_CFG_DELAY_LSB];
    assign cfg_taps   = r.cfg[`FDPO_CFG_TAPS_MSB:`FDPO_CFG_TAPS_LSB];
    assign cfg_asym   = r.cfg[`FDPO_CFG_ASYM_BIT];
    assign cfg_odd    = r.cfg[`FDPO_CFG_ODD_BIT];
    assign cfg_decim  = r.cfg[`FDPO_CFG_DECIM_MSB:`FDPO_CFG_DECIM_LSB];
    assign cfg_enable = r.cfg[`FDPO_CFG_ENABLE_BIT];
    assign cfg_pmul   = r.cfg[`FDPO_CFG_PMUL_MSB:`FDPO_CFG_PMUL_LSB];
    assign fir_sel    = fdpo_fsel_t'(path_option_in[`FDPO_OPT_FSEL_MSB:`FDPO_OPT_FSEL_LSB]);
    assign q_zero     = path_option_in[`FDPO_OPT_QZERO_BIT];
    assign a_sel      = fdpo_asel_t'(out_format_in[`FDPO_FMT_ASEL_MSB:`FDPO_FMT_ASEL_LSB]);
    assign b_sel      = fdpo_bsel_t'(out_format_in[`FDPO_FMT_BSEL_MSB:`FDPO_FMT_BSEL_LSB]);
    assign par_mode   = ~out_format_in[`FDPO_FMT_MODE_BIT];

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // shift left wraps naturally in the 18-bit turn
    function automatic logic [17:0] phase_mul(input logic [17:0] ph, input logic [1:0] code);
        phase_mul = 18'(ph << code);
    endfunction

    // D field: code 0 stands for 8, codes 1..7 are direct
    function automatic logic [3:0] comb_depth(input logic [2:0] code);
        comb_depth = (code == 3'h0) ? 4'(`FDPO_MAX_DELAY) : {1'b0, code};
    endfunction

    // ---------------------------------------------------------------
    // fir input and converter feed
    // ---------------------------------------------------------------
    logic        fir_valid;
    logic [15:0] fir_data;
    logic [17:0] cur_phase;
    logic [17:0] old_phase;
    logic [3:0]  depth;

    always_comb begin
        cur_phase = phase_mul(converter_in.phase, cfg_pmul);
        depth     = comb_depth(cfg_delay);
        old_phase = r.hist[3'(depth - 4'h1)];
    end

    always_comb begin
        logic conv_load;
        // converter loads from agc or resampler depending on bypass
        conv_load = resampler_enable_in ? resampler_ready_in : agc_ready_in;
        next_r = r;
        next_r.fir_in_valid = 1'b0;
        next_r.freq_new = 1'b0;
        next_r.par.strobe = 1'b0;
        next_r.conv_iq.strobe = 1'b0;

        if (cfg_we_in) begin
            next_r.cfg = cfg_in;
        end

        if (conv_load) begin
            next_r.conv_iq = resampler_enable_in ? resampler_iq_in : agc_iq_in;
            if (q_zero) begin
                next_r.conv_iq.q = 18'h0_0000;
            end
            next_r.conv_iq.strobe = 1'b1;
            // I/Q held for output, so polar results trail by one sample
            next_r.sym_iq = next_r.conv_iq;
        end

        if (cfg_enable) begin
            unique case (fir_sel)
                FDPO_SRC_PHASE: begin
                    if (converter_in.strobe) begin
                        next_r.fir_in = 18'(cur_phase - old_phase);
                        next_r.fir_in_valid = 1'b1;
                        next_r.hist[0] = cur_phase;
                        for (int k = 1; k < `FDPO_MAX_DELAY; k++) begin
                            next_r.hist[k] = r.hist[k-1];
                        end
                    end
                end
                FDPO_SRC_MAG: begin
                    if (converter_in.strobe) begin
                        next_r.fir_in = converter_in.mag;
                        next_r.fir_in_valid = 1'b1;
                    end
                end
                FDPO_SRC_RSI, FDPO_SRC_RSI2: begin
                    if (resampler_ready_in) begin
                        next_r.fir_in = resampler_iq_in.i;
                        next_r.fir_in_valid = 1'b1;
                    end
                end
            endcase
        end

        if (fir_valid) begin
            next_r.freq = fir_data;
            next_r.freq_new = 1'b1;
        end

        // -----------------------------------------------------------
        // parallel output formatter
        // -----------------------------------------------------------
        if (par_mode) begin
            unique case (a_sel)
                FDPO_A_I: begin
                    if (r.sym_iq.strobe) begin
                        next_r.par.word_a = r.sym_iq.i[17:2];
                        next_r.par.strobe = 1'b1;
                    end
                end
                FDPO_A_MAG: begin
                    if (converter_in.strobe) begin
                        next_r.par.word_a = converter_in.mag[17:2];
                        next_r.par.strobe = 1'b1;
                    end
                end
                FDPO_A_FREQ: begin
                    if (r.freq_new) begin
                        next_r.par.word_a = r.freq;
                        next_r.par.strobe = 1'b1;
                    end
                end
                default: next_r.par.word_a = r.par.word_a;
            endcase
            unique case (b_sel)
                FDPO_B_Q: begin
                    if (r.sym_iq.strobe) begin
                        next_r.par.word_b = r.sym_iq.q[17:2];
                    end
                end
                FDPO_B_PH: begin
                    if (converter_in.strobe) begin
                        next_r.par.word_b = converter_in.phase[17:2];
                    end
                end
                FDPO_B_MAG: begin
                    if (converter_in.strobe) begin
                        next_r.par.word_b = converter_in.mag[17:2];
                    end
                end
                default: next_r.par.word_b = r.par.word_b;
            endcase
        end
        // symbol strobe lasts one cycle only
        if (!conv_load) begin
            next_r.sym_iq.strobe = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // discriminator fir
    // ---------------------------------------------------------------
    fdpo_fir u_fir (
        .sys_clk_in      (sys_clk_in),
        .rst_n_in        (rst_n_in),
        .ce_in           (ce_in),
        .sample_valid_in (r.fir_in_valid),
        .sample_in       (r.fir_in),
        .taps_in         (cfg_taps),
        .asym_in         (cfg_asym),
        .odd_sym_in      (cfg_odd),
        .decim_in        (cfg_decim),
        .coef_we_in      (coef_we_in),
        .coef_addr_in    (coef_addr_in),
        .coef_in         (coef_in),
        .out_valid_out   (fir_valid),
        .out_data_out    (fir_data)
    );

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            r <= '0;
            r.cfg <= `FDPO_CFG_RESET;
        end else if (ce_in) begin
            r <= next_r;
        end
    end

    assign cfg_out                = r.cfg;
    assign converter_iq_out       = r.conv_iq;
    assign parallel_word_a_out    = r.par.word_a;
    assign parallel_word_b_out    = r.par.word_b;
    assign output_word_strobe_out = r.par.strobe;
endmodule
`default_nettype wire
